// ==== hw/trace_trigger_pkg.sv ====
// Constants for the trace trigger and status block.
// Assumes an APB master with 32-bit data and word-aligned registers.
package trace_trigger_pkg;
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] TRIGGER_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] FIFO_HIGH_OFS = 8'h0C;
  localparam logic [7:0] FIFO_LOW_OFS = 8'h10;
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_ARM_BIT = 6;
  localparam int TRG_QUALIFY_BIT = 7;
  localparam int TRG_BEGIN_BIT = 6;
  localparam logic [7:0] TRG_WRITE_MASK = 8'hCF;
  localparam int STS_MATCH_A_BIT = 7;
  localparam int STS_MATCH_B_BIT = 6;
  localparam int STS_ARMED_BIT = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_RESET = 8'h00;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVENT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_WAIT_A = 2'b01,
    RUN_STORE = 2'b10
  } run_state_e;
endpackage

// ==== hw/trace_trigger.sv ====
// Trigger selection, capture control and status of the bus-analysis debug unit.
// Assumes comparator match pulses and an opcode-executed indication from the same clock domain.
// Function
// (R1) Trigger config writable only while disarmed
// (R2) Opcode qualify gates matches on execution
// (R3) Begin bit selects begin/end capture
// (R4) Event-only modes always act as begin
// (R5) Modes 0-2: A, A or B, A then B
// (R6) Modes 3-4: store on B events
// (R7) Modes 5-6: A with B data match; mode 6 here triggers on A with no B data match
// (R8) Modes 7-8: inside or outside range
// (R9) Modes 9-15 never trigger
// (R10) Match A flag cleared at start
// (R11) Match B flag cleared at start
// (R12) Armed flag mirrors arm while enabled
// (R13) Run ends on full or trigger
// (R14) Clearing arm or enable stops run
// (R15) Valid count cleared, counts to eight
// (R16) Valid count fixed during readout
// (R17) Host tracks remaining words itself
// (R18) Status register is read-only
// (R19) Low-byte read advances, high-byte does not
// (R20) Arm write sets flag; run end clears
// (R21) Status bit 4 reads zero
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module trace_trigger
  import trace_trigger_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_a_match,
  input wire logic cmp_b_match,
  input wire logic data_b_match,
  input wire logic addr_ge_a,
  input wire logic addr_le_b,
  input wire logic bus_access,
  input wire logic opcode_executed,
  input wire logic store_strobe,
  input wire logic [15:0] store_word,
  output logic capture_active,
  output logic trigger_pulse
);
  import trace_trigger_pkg::*;

  logic [7:0] control_reg;
  logic [7:0] trigger_reg;
  logic match_a_reg;
  logic match_b_reg;
  logic [3:0] count_reg;
  logic [15:0] fifo_mem [FIFO_DEPTH];
  logic [2:0] wr_ptr_reg;
  logic [2:0] rd_ptr_reg;
  logic [15:0] fifo_out;
  run_state_e state_reg;
  run_state_e state_next;

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic trace_unit_enable;
  logic arm;
  logic opcode_qualify_select;
  logic begin_select;
  logic [3:0] trigger_mode_field;
  logic hit_a;
  logic hit_b;
  logic event_only;
  logic begin_trace;
  logic trig;
  logic store;
  logic fifo_full;
  logic run_end;
  logic arm_set;
  logic armed_flag;
  logic ctl_stop;

  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == CONTROL_OFS) || (paddr == TRIGGER_OFS) || (paddr == STATUS_OFS) ||
                  (paddr == FIFO_HIGH_OFS) || (paddr == FIFO_LOW_OFS);
  assign pslverr = psel && penable && !mapped;

  assign trace_unit_enable = control_reg[CTL_ENABLE_BIT];
  assign arm = control_reg[CTL_ARM_BIT];
  assign armed_flag = trace_unit_enable && arm; // R12
  assign capture_active = armed_flag;
  assign opcode_qualify_select = trigger_reg[TRG_QUALIFY_BIT];
  assign begin_select = trigger_reg[TRG_BEGIN_BIT];
  assign trigger_mode_field = trigger_reg[3:0];

  // Tag mode only lets a match through once the opcode actually executes
  assign hit_a = cmp_a_match && (!opcode_qualify_select || opcode_executed); // R2
  assign hit_b = cmp_b_match && (!opcode_qualify_select || opcode_executed); // R2

  assign event_only = (trigger_mode_field == MODE_EVENT_B) || (trigger_mode_field == MODE_A_THEN_EVENT_B);
  assign begin_trace = event_only || begin_select; // R3 R4
  assign fifo_full = (count_reg == 4'(FIFO_DEPTH));

  always_comb begin
    trig = 1'b0;
    case (trigger_mode_field)
      MODE_A_ONLY: trig = hit_a; // R5
      MODE_A_OR_B: trig = hit_a || hit_b; // R5
      MODE_A_THEN_B: trig = (state_reg == RUN_STORE) && hit_b; // R5
      MODE_EVENT_B: trig = hit_b; // R6
      MODE_A_THEN_EVENT_B: trig = (state_reg == RUN_STORE) && hit_b; // R6
      MODE_A_AND_B: trig = hit_a && data_b_match; // R7
      MODE_A_AND_NOT_B: trig = hit_a && !data_b_match; // R7
      MODE_INSIDE: trig = bus_access && addr_ge_a && addr_le_b; // R8
      MODE_OUTSIDE: trig = bus_access && (!addr_ge_a || !addr_le_b); // R8
      default: trig = 1'b0; // R9
    endcase
    if (state_reg == RUN_IDLE) begin
      trig = 1'b0;
    end
  end
  assign trigger_pulse = trig;

  // Event-only modes store on each B event (mode 4 only once A has hit); others store the change-of-flow stream
  always_comb begin
    store = 1'b0;
    if (state_reg != RUN_IDLE) begin
      if (event_only) begin
        store = trig; // R6
      end else if (begin_trace) begin
        store = store_strobe && (state_reg == RUN_STORE); // R3
      end else begin
        store = store_strobe; // R3
      end
    end
  end

  assign run_end = (state_reg != RUN_IDLE) &&
                   ((begin_trace && fifo_full) || (!begin_trace && trig)); // R13
  assign arm_set = wr_acc && (paddr == CONTROL_OFS) && pwdata[CTL_ARM_BIT] && pwdata[CTL_ENABLE_BIT];
  // A stop write ends the run at its own edge, not a cycle later, so no stray word lands
  assign ctl_stop = wr_acc && (paddr == CONTROL_OFS) && !(pwdata[CTL_ARM_BIT] && pwdata[CTL_ENABLE_BIT]);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RUN_IDLE: begin
        if (arm_set) begin
          state_next = (begin_trace || trigger_mode_field == MODE_A_THEN_B) ? RUN_WAIT_A : RUN_STORE;
        end
      end
      RUN_WAIT_A: begin
        if (trigger_mode_field == MODE_EVENT_B) begin
          state_next = RUN_STORE;
        end else if ((trigger_mode_field == MODE_A_THEN_B || trigger_mode_field == MODE_A_THEN_EVENT_B) && hit_a) begin
          state_next = RUN_STORE;
        end else if (begin_trace && !event_only && trig) begin
          state_next = RUN_STORE; // R3
        end
      end
      RUN_STORE: state_next = RUN_STORE;
      default: state_next = RUN_IDLE;
    endcase
    if (run_end || !armed_flag || ctl_stop) begin
      state_next = RUN_IDLE; // R13 R14
    end
    if (state_reg == RUN_IDLE && arm_set) begin
      state_next = (trigger_mode_field == MODE_A_THEN_B || trigger_mode_field == MODE_A_THEN_EVENT_B ||
                    (begin_trace && !event_only)) ? RUN_WAIT_A : (event_only ? RUN_STORE : RUN_STORE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= RUN_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= CONTROL_RESET;
    end else if (wr_acc && paddr == CONTROL_OFS) begin
      control_reg <= pwdata[7:0]; // R14 R20
    end else if (run_end) begin
      control_reg[CTL_ARM_BIT] <= 1'b0; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_reg <= TRIGGER_RESET;
    end else if (wr_acc && paddr == TRIGGER_OFS && !arm) begin
      trigger_reg <= pwdata[7:0] & TRG_WRITE_MASK; // R1
    end
  end

  // Flags: a new run clears them; a match in that same cycle cannot occur since idle blocks matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_reg <= 1'b0;
      match_b_reg <= 1'b0;
    end else if (arm_set && state_reg == RUN_IDLE) begin
      match_a_reg <= 1'b0; // R10
      match_b_reg <= 1'b0; // R11
    end else if (state_reg != RUN_IDLE) begin
      if (hit_a) begin
        match_a_reg <= 1'b1; // R10
      end
      if (hit_b) begin
        match_b_reg <= 1'b1; // R11
      end
    end
  end

  // End trace wraps the buffer, so the count saturates at the depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 4'h0;
      wr_ptr_reg <= 3'h0;
    end else if (arm_set && state_reg == RUN_IDLE) begin
      count_reg <= 4'h0; // R15
      wr_ptr_reg <= 3'h0;
    end else if (store && !(begin_trace && fifo_full)) begin
      wr_ptr_reg <= wr_ptr_reg + 3'h1;
      if (!fifo_full) begin
        count_reg <= count_reg + 4'h1; // R15
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (store && !(begin_trace && fifo_full)) begin
      fifo_mem[wr_ptr_reg] <= event_only ? {8'h00, store_word[7:0]} : store_word;
    end
  end

  // Oldest word first after end trace; count is never touched by reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg <= 3'h0;
    end else if (run_end) begin
      rd_ptr_reg <= (begin_trace || !fifo_full) ? 3'h0 : wr_ptr_reg + (store ? 3'h1 : 3'h0);
    end else if (rd_acc && paddr == FIFO_LOW_OFS && !armed_flag) begin
      rd_ptr_reg <= rd_ptr_reg + 3'h1; // R19 R16
    end
  end
  assign fifo_out = fifo_mem[rd_ptr_reg];

  // Status writes fall through with no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        CONTROL_OFS: prdata <= {24'h000000, control_reg};
        TRIGGER_OFS: prdata <= {24'h000000, trigger_reg};
        STATUS_OFS: prdata <= {24'h000000, match_a_reg, match_b_reg, armed_flag, 1'b0, count_reg}; // R18 R21
        FIFO_HIGH_OFS: prdata <= {24'h000000, fifo_out[15:8]};
        FIFO_LOW_OFS: prdata <= {24'h000000, fifo_out[7:0]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  property p_trig_locked;
    @(posedge pclk) disable iff (!presetn)
      arm && wr_acc && paddr == TRIGGER_OFS |=> $stable(trigger_reg);
  endproperty
  a_trig_locked: assert property (p_trig_locked) else $error("trigger config changed while armed"); // R1

  property p_bits45_zero;
    @(posedge pclk) disable iff (!presetn) trigger_reg[5:4] == 2'b00;
  endproperty
  a_bits45_zero: assert property (p_bits45_zero) else $error("trigger bits 5:4 not zero"); // R1

  property p_qualify;
    @(posedge pclk) disable iff (!presetn)
      opcode_qualify_select && !opcode_executed && !data_b_match && trigger_mode_field == MODE_A_ONLY |-> !trig;
  endproperty
  a_qualify: assert property (p_qualify) else $error("unqualified match triggered"); // R2

  property p_no_trig_high;
    @(posedge pclk) disable iff (!presetn) trigger_mode_field > MODE_OUTSIDE |-> !trig;
  endproperty
  a_no_trig_high: assert property (p_no_trig_high) else $error("reserved mode triggered"); // R9

  property p_end_trace;
    @(posedge pclk) disable iff (!presetn) trig && !begin_trace |=> !armed_flag ##1 !armed_flag;
  endproperty
  a_end_trace: assert property (p_end_trace) else $error("end trace run kept going"); // R13

  property p_manual_stop;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == CONTROL_OFS && !pwdata[CTL_ARM_BIT] |=> state_reg == RUN_IDLE;
  endproperty
  a_manual_stop: assert property (p_manual_stop) else $error("run not stopped"); // R14

  property p_count_max;
    @(posedge pclk) disable iff (!presetn) count_reg <= 4'(FIFO_DEPTH);
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above eight"); // R15

  property p_count_read;
    @(posedge pclk) disable iff (!presetn) rd_acc && state_reg == RUN_IDLE && !arm_set |=> $stable(count_reg);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count moved on read"); // R16

  property p_arm_mirror;
    @(posedge pclk) disable iff (!presetn) arm_set |=> armed_flag;
  endproperty
  a_arm_mirror: assert property (p_arm_mirror) else $error("armed flag not set"); // R12

  property p_high_read;
    @(posedge pclk) disable iff (!presetn) rd_acc && paddr == FIFO_HIGH_OFS && !run_end |=> $stable(rd_ptr_reg);
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read advanced fifo"); // R19

  // Both the run state and the armed flag must be down once a run is over
  sequence s_run_over;
    !armed_flag && state_reg == RUN_IDLE;
  endsequence

  property p_stop_enable;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == CONTROL_OFS && !pwdata[CTL_ENABLE_BIT] |=> s_run_over;
  endproperty
  a_stop_enable: assert property (p_stop_enable) else $error("disable did not end run"); // R14

  property p_flags_clear;
    @(posedge pclk) disable iff (!presetn)
      arm_set && state_reg == RUN_IDLE |=> !match_a_reg && !match_b_reg;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("match flags not cleared at start"); // R10

  property p_count_clear;
    @(posedge pclk) disable iff (!presetn)
      arm_set && state_reg == RUN_IDLE |=> count_reg == 4'h0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("valid count not cleared at start"); // R15

  property p_b_flag_set;
    @(posedge pclk) disable iff (!presetn)
      state_reg != RUN_IDLE && hit_b |=> match_b_reg;
  endproperty
  a_b_flag_set: assert property (p_b_flag_set) else $error("match b flag not set"); // R11

  property p_begin_full;
    @(posedge pclk) disable iff (!presetn)
      begin_trace && fifo_full && state_reg != RUN_IDLE && !(wr_acc && paddr == CONTROL_OFS) |=> s_run_over;
  endproperty
  a_begin_full: assert property (p_begin_full) else $error("begin trace run kept going when full"); // R13

  property p_event_full;
    @(posedge pclk) disable iff (!presetn)
      event_only && !begin_select && fifo_full && state_reg != RUN_IDLE && !(wr_acc && paddr == CONTROL_OFS) |=> s_run_over;
  endproperty
  a_event_full: assert property (p_event_full) else $error("event run not treated as begin trace"); // R4

  property p_a_only;
    @(posedge pclk) disable iff (!presetn)
      trigger_mode_field == MODE_A_ONLY && !opcode_qualify_select && state_reg != RUN_IDLE |-> trig == cmp_a_match;
  endproperty
  a_a_only: assert property (p_a_only) else $error("a-only trigger wrong"); // R5

  property p_event_store;
    @(posedge pclk) disable iff (!presetn)
      event_only && state_reg == RUN_STORE && hit_b && !fifo_full |=> count_reg == $past(count_reg) + 4'h1;
  endproperty
  a_event_store: assert property (p_event_store) else $error("b event not stored"); // R6

  property p_low_read;
    @(posedge pclk) disable iff (!presetn)
      rd_acc && paddr == FIFO_LOW_OFS && !armed_flag && !run_end |=> rd_ptr_reg == $past(rd_ptr_reg) + 3'h1;
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read did not advance fifo"); // R19
endmodule

// ==== verification/bus_activity_model.sv ====
// Stand-in for CPU bus activity: comparator matches and change-of-flow words.
// Assumes one request code per cycle from the bench, sampled on pclk.
`timescale 1ns/1ps
module bus_activity_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] req,
  input wire logic [1:0] kind,
  output logic cmp_a_match,
  output logic cmp_b_match,
  output logic data_b_match,
  output logic addr_ge_a,
  output logic addr_le_b,
  output logic bus_access,
  output logic opcode_executed,
  output logic store_strobe,
  output logic [15:0] store_word
);
  logic [15:0] word_reg;
  // Kind picks what codes 1 and 2 mean: plain A/B, A with or without data match,
  // access inside or below the range, A with or without the opcode executing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_match <= 1'b0;
      cmp_b_match <= 1'b0;
      data_b_match <= 1'b0;
      addr_ge_a <= 1'b0;
      addr_le_b <= 1'b0;
      bus_access <= 1'b0;
      opcode_executed <= 1'b0;
      store_strobe <= 1'b0;
    end else begin
      cmp_a_match <= (req == 2'd1 && kind != 2'd2) || (req == 2'd2 && kind[0]);
      cmp_b_match <= req == 2'd2 && kind == 2'd0;
      data_b_match <= req == 2'd1 && kind == 2'd1;
      addr_ge_a <= req == 2'd1 && kind == 2'd2;
      addr_le_b <= req != 2'd0 && req != 2'd3 && kind == 2'd2;
      bus_access <= req != 2'd0 && req != 2'd3 && kind == 2'd2;
      opcode_executed <= req == 2'd1 && kind == 2'd3;
      store_strobe <= req == 2'd3;
    end
  end
  // Word is only meaningful with its strobe; otherwise it toggles so stale data is not trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= 16'h1234;
      store_word <= 16'h0000;
    end else if (req == 2'd3) begin
      word_reg <= word_reg + 16'h0101;
      store_word <= word_reg;
    end else begin
      store_word <= ~store_word;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the trace trigger and status block.
// Assumes the bus activity model on the far side and an APB master here.
`timescale 1ns/1ps
module tb_top;
  import trace_trigger_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cap, trg, am, bm, dbm, ge, le, ba, ox, ss;
  logic [15:0] sw;
  logic [1:0] req = 2'd0;
  logic [1:0] kind = 2'd0;
  int error_cnt = 0, checks = 0;
  int trg_cnt = 0;
  always #25 pclk = ~pclk;
  always @(posedge pclk)
    if (trg === 1'b1) trg_cnt <= trg_cnt + 1;
  trace_trigger i_trace_trigger (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_a_match(am), .cmp_b_match(bm), .data_b_match(dbm), .addr_ge_a(ge), .addr_le_b(le),
    .bus_access(ba), .opcode_executed(ox), .store_strobe(ss), .store_word(sw), .capture_active(cap),
    .trigger_pulse(trg));
  bus_activity_model i_bus_activity_model (.pclk(pclk), .presetn(presetn), .req(req), .kind(kind),
    .cmp_a_match(am), .cmp_b_match(bm), .data_b_match(dbm), .addr_ge_a(ge), .addr_le_b(le),
    .bus_access(ba), .opcode_executed(ox), .store_strobe(ss), .store_word(sw));
  task tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Entered just after a rising edge; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
    rd = prdata;
    cmp("pslverr", {7'h0, a > FIFO_LOW_OFS}, {7'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input string name, input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(name, exp, rd[7:0] & mask);
  endtask
  task ev(input logic [1:0] c, input int n);
    repeat (n) begin
      req <= c;
      @(posedge pclk);
      req <= 2'd0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task arm();
    apb(1'b1, CONTROL_OFS, 32'hC0);
  endtask
  task t_reset_ro();
    chk("status_rst", STATUS_OFS, 8'hFF, 8'h00);
    apb(1'b1, STATUS_OFS, 32'hFF);
    chk("status_wr", STATUS_OFS, 8'hFF, 8'h00);
    chk("unmapped", 8'h14, 8'hFF, 8'h00);
  endtask
  task t_no_trigger();
    for (int m = 9; m < 16; m++) begin
      apb(1'b1, CONTROL_OFS, 32'h0);
      apb(1'b1, TRIGGER_OFS, 32'h30 | m);
      chk("trg_rd", TRIGGER_OFS, 8'hFF, 8'(m));
      arm();
      chk("armed", STATUS_OFS, 8'hFF, 8'h20);
      ev(2'd1, 1);
      ev(2'd2, 1);
      chk("no_trg", STATUS_OFS, 8'h20, 8'h20);
      apb(1'b1, TRIGGER_OFS, 32'h00);
      chk("trg_lock", TRIGGER_OFS, 8'hFF, 8'(m));
      apb(1'b1, CONTROL_OFS, (m % 2) ? 32'h80 : 32'h40);
      chk("stop", STATUS_OFS, 8'h20, 8'h00);
    end
    cmp("no_trg_pulse", 8'h00, 8'(trg_cnt));
  endtask
  task t_end_trace();
    apb(1'b1, TRIGGER_OFS, 32'h00);
    arm();
    ev(2'd3, 3);
    ev(2'd1, 1);
    chk("end_run", STATUS_OFS, 8'hFF, 8'h83);
    chk("arm_clr", CONTROL_OFS, 8'hC0, 8'h80);
  endtask
  task t_begin_trace();
    int left;
    apb(1'b1, TRIGGER_OFS, 32'h40);
    arm();
    chk("flags_clr", STATUS_OFS, 8'hFF, 8'h20);
    ev(2'd3, 1);
    ev(2'd1, 1);
    ev(2'd3, 7);
    chk("not_full", STATUS_OFS, 8'h20, 8'h20);
    ev(2'd3, 2);
    chk("full", STATUS_OFS, 8'hFF, 8'h88);
    left = 8;
    while (left > 5) begin
      apb(1'b0, FIFO_HIGH_OFS, 32'h0);
      cmp("fifo_hi", 8'h1E - 8'(left), rd[7:0]);
      apb(1'b0, FIFO_HIGH_OFS, 32'h0);
      cmp("fifo_hi_again", 8'h1E - 8'(left), rd[7:0]);
      apb(1'b0, FIFO_LOW_OFS, 32'h0);
      cmp("fifo_lo", 8'h40 - 8'(left), rd[7:0]);
      left--;
    end
    chk("cnt_hold", STATUS_OFS, 8'hFF, 8'h88);
  endtask
  task t_event_b();
    apb(1'b1, TRIGGER_OFS, {28'h0, MODE_EVENT_B});
    arm();
    ev(2'd2, 7);
    chk("evt_run", STATUS_OFS, 8'h20, 8'h20);
    ev(2'd2, 1);
    chk("evt_full", STATUS_OFS, 8'hFF, 8'h48);
  endtask
  // One run: a miss must not trigger, then an optional step, then exactly one trigger
  task run_mode(input logic [1:0] k, input logic [7:0] t, input logic [1:0] miss, input logic [1:0] pre,
                input logic [1:0] hit, input logic [7:0] exp);
    int c0;
    kind <= k;
    apb(1'b1, TRIGGER_OFS, {24'h0, t});
    arm();
    cmp("cap_on", 8'h01, {7'h0, cap});
    c0 = trg_cnt;
    ev(miss, 1);
    chk("miss_armed", STATUS_OFS, 8'h20, 8'h20);
    cmp("miss_trig", 8'h00, 8'(trg_cnt - c0));
    ev(pre, 1);
    ev(hit, 1);
    chk("hit_status", STATUS_OFS, 8'hFF, exp);
    cmp("hit_trig", 8'h01, 8'(trg_cnt - c0));
    apb(1'b1, CONTROL_OFS, 32'h80);
    cmp("cap_off", 8'h00, {7'h0, cap});
  endtask
  task t_modes();
    run_mode(2'd0, 8'h01, 2'd0, 2'd0, 2'd2, 8'h40);
    run_mode(2'd0, 8'h02, 2'd2, 2'd1, 2'd2, 8'hC0);
    run_mode(2'd0, 8'h04, 2'd2, 2'd1, 2'd2, 8'hE1);
    run_mode(2'd1, 8'h05, 2'd2, 2'd0, 2'd1, 8'h80);
    run_mode(2'd1, 8'h06, 2'd1, 2'd0, 2'd2, 8'h80);
    run_mode(2'd2, 8'h07, 2'd2, 2'd0, 2'd1, 8'h00);
    run_mode(2'd2, 8'h08, 2'd1, 2'd0, 2'd2, 8'h00);
    run_mode(2'd3, 8'h80, 2'd2, 2'd0, 2'd1, 8'h80);
    kind <= 2'd0;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_ro();
    t_no_trigger();
    t_end_trace();
    t_begin_trace();
    t_event_b();
    t_modes();
    tally_and_finish();
  end
endmodule
